// File: hdl/lvd_top.sv
`default_nettype none

module lvd_top
  import lvd_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic                       hsel,
  input  wire logic [ADDR_W-1:0]          haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic      [31:0]                hrdata,
  output logic                            hresp,
  input  wire logic                       supply_below,
  input  wire logic                       pin_below,
  output logic                            comparator_enable,
  output logic                            source_select,
  output logic      [lvd_pkg::LEVEL_W-1:0] threshold_level_select,
  output logic                            detector_reset_req,
  output logic                            detector_reset_cause,
  output logic                            irq
);

  lvd_core_if core ();

  logic                 a_valid_reg;
  logic                 a_write_reg;
  logic [7:0]           a_addr_reg;
  logic                 addr_take;
  logic [7:0]           addr_low;
  logic                 wr_ctrl;
  logic                 wr_set;
  logic                 wr_clr;
  logic                 wr_level;
  logic                 wr_cause;
  logic                 wr_stat;
  logic                 wr_mask;
  logic [7:0]           wbyte;
  logic                 enable_reg;
  logic                 source_reg;
  logic                 mode_reg;
  logic [LEVEL_W-1:0]   level_reg;
  logic                 cause_reg;
  logic                 cause_next;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  logic [CTRL_W-1:0]    ctrl_view;
  logic [31:0]          rdata_next;

  // ****************************************
  // AHB-Lite address phase
  // ****************************************
  assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign addr_low  = 8'(haddr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_valid_reg <= 1'b0;
      a_write_reg <= 1'b0;
      a_addr_reg  <= 8'h00;
    end else if (clk_en && hready) begin
      a_valid_reg <= addr_take;
      a_write_reg <= hwrite;
      a_addr_reg  <= addr_low;
    end
  end

  // Zero wait states; all answers are OKAY, unmapped reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // ****************************************
  // Data phase write decode
  // ****************************************
  // Registers sit in byte lane 0, so byte, half and word writes all reach them
  assign wbyte    = hwdata[7:0];
  assign wr_ctrl  = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_CTRL);
  assign wr_set   = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_CTRL_SET);
  assign wr_clr   = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_CTRL_CLR);
  assign wr_level = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_LEVEL);
  assign wr_cause = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_CAUSE);
  assign wr_stat  = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_IRQ_STAT);
  assign wr_mask  = a_valid_reg & a_write_reg & (a_addr_reg == ADDR_IRQ_MASK);

  // ****************************************
  // Control register
  // ****************************************
  // Only the outside reset clears it; the detector's own reset request never
  // reaches rst_b, so the settings survive a detector reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= CTRL_RESET_BIT;
      source_reg <= CTRL_RESET_BIT;
      mode_reg   <= CTRL_RESET_BIT;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        enable_reg <= wbyte[CTRL_ENABLE];
        source_reg <= wbyte[CTRL_SOURCE];
        mode_reg   <= wbyte[CTRL_MODE];
      end else if (wr_set) begin
        enable_reg <= enable_reg | wbyte[CTRL_ENABLE];
        source_reg <= source_reg | wbyte[CTRL_SOURCE];
        mode_reg   <= mode_reg | wbyte[CTRL_MODE];
      end else if (wr_clr) begin
        enable_reg <= enable_reg & ~wbyte[CTRL_ENABLE];
        source_reg <= source_reg & ~wbyte[CTRL_SOURCE];
        mode_reg   <= mode_reg & ~wbyte[CTRL_MODE];
      end
    end
  end

  assign core.detect_enable       = enable_reg;
  assign core.source_select       = source_reg;
  assign core.reset_or_irq_select = mode_reg;

  // Bits 6..3 are constant zero and the flag comes from the detector
  always_comb begin
    ctrl_view              = '0;
    ctrl_view[CTRL_ENABLE] = enable_reg;
    ctrl_view[CTRL_SOURCE] = source_reg;
    ctrl_view[CTRL_MODE]   = mode_reg;
    ctrl_view[CTRL_FLAG]   = core.below_threshold_flag;
  end

  // ****************************************
  // Threshold level select
  // ****************************************
  // Changing the level while enabled may glitch the comparator; software's job
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_reg <= LEVEL_RESET;
    end else if (clk_en && wr_level) begin
      level_reg <= wbyte[LEVEL_W-1:0];
    end
  end

  // ****************************************
  // Reset cause flag
  // ****************************************
  // A request in the cycle of a clear keeps the flag set
  assign cause_next = (cause_reg & ~(wr_cause & wbyte[CAUSE_DETECTOR])) | core.reset_req;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_reg <= CAUSE_RESET;
    end else if (clk_en) begin
      cause_reg <= cause_next;
    end
  end

  // ****************************************
  // Detector and interrupt logic
  // ****************************************
  // Runs on whatever clock stays alive in stop mode; nothing here needs the CPU
  lvd_detect u_detect (
    .clk          (clk),
    .rst_b        (rst_b),
    .clk_en       (clk_en),
    .supply_below (supply_below),
    .pin_below    (pin_below),
    .core         (core.detect)
  );

  lvd_irq u_irq (
    .clk      (clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .event_in ({core.recover_event, core.below_event}),
    .stat_wr  (wr_stat),
    .mask_wr  (wr_mask),
    .wdata    (wbyte[IRQ_W-1:0]),
    .status   (irq_status),
    .mask     (irq_mask),
    .irq      (irq)
  );

  // ****************************************
  // Read data, registered at the address phase
  // ****************************************
  always_comb begin
    rdata_next = '0;
    case (addr_low)
      ADDR_CTRL:     rdata_next[CTRL_W-1:0]   = ctrl_view;
      ADDR_LEVEL:    rdata_next[LEVEL_W-1:0]  = level_reg;
      ADDR_CAUSE:    rdata_next[CAUSE_DETECTOR] = cause_reg;
      ADDR_IRQ_STAT: rdata_next[IRQ_W-1:0]    = irq_status;
      ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0]    = irq_mask;
      default:       rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && addr_take && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // ****************************************
  // Outputs to comparator and reset controller
  // ****************************************
  assign comparator_enable      = enable_reg;
  assign source_select          = source_reg;
  assign threshold_level_select = level_reg;
  assign detector_reset_req     = core.reset_req;
  assign detector_reset_cause   = cause_reg;

endmodule

`default_nettype wire

// File: hdl/lvd_pkg.sv
// Overview of operation
// - Software picks whether a low-voltage detection raises reset or interrupt.
// - Control bit 2 selects supply comparison at 0, external pin at 1.
// - Control bit 1 selects reset mode at 1, interrupt mode at 0.
// - Reset mode holds reset while voltage is below threshold, releases at/above.
// - Interrupt mode interrupts on falling below and on returning at/above threshold.
// - While enabled, control bit 0 reads 1 when below threshold, else 0.
// - A detector-caused reset sets bit 0 of the reset cause register.
// - Other resets clear the control register; a detector reset leaves it.
// - Sixteen supply thresholds chosen through a separate level-select output.
// - Detection, reset and interrupt keep working in stop mode.
// - Control register accepts single-bit and whole-byte writes.
// - Enable bit 7 starts the comparator; clearing it stops detection, flag 0.
// - Control bit 0 is read-only; writes to it do nothing.
`default_nettype none

package lvd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LEVEL    = 8'h04;
  localparam logic [7:0] ADDR_CAUSE    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_CTRL_SET = 8'h14;
  localparam logic [7:0] ADDR_CTRL_CLR = 8'h18;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          CTRL_W         = 8;
  localparam int          CTRL_ENABLE    = 7;
  localparam int          CTRL_SOURCE    = 2;
  localparam int          CTRL_MODE      = 1;
  localparam int          CTRL_FLAG      = 0;
  localparam logic        CTRL_RESET_BIT = 1'h0;
  localparam int          LEVEL_W        = 4;
  localparam logic [3:0]  LEVEL_RESET    = 4'h0;
  localparam int          CAUSE_DETECTOR = 0;
  localparam logic        CAUSE_RESET    = 1'h0;
  localparam int          IRQ_W          = 2;
  localparam int          IRQ_BELOW      = 0;
  localparam int          IRQ_RECOVER    = 1;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  // ****************************************
  // AHB-Lite encodings
  // ****************************************
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic        HRESP_OKAY     = 1'h0;
  localparam logic [1:0]  LANE0_OFFSET   = 2'h0;

endpackage

`default_nettype wire

// File: hdl/lvd_core_if.sv
`default_nettype none

interface lvd_core_if;
  logic detect_enable;
  logic source_select;
  logic reset_or_irq_select;
  logic below_threshold_flag;
  logic below_event;
  logic recover_event;
  logic reset_req;

  modport detect (
    input  detect_enable,
    input  source_select,
    input  reset_or_irq_select,
    output below_threshold_flag,
    output below_event,
    output recover_event,
    output reset_req
  );

  modport ctrl (
    output detect_enable,
    output source_select,
    output reset_or_irq_select,
    input  below_threshold_flag,
    input  below_event,
    input  recover_event,
    input  reset_req
  );
endinterface

`default_nettype wire

// File: hdl/lvd_detect.sv
`default_nettype none

module lvd_detect
  import lvd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic supply_below,
  input  wire logic pin_below,
  lvd_core_if.detect core
);

  logic below_sel;
  logic flag_next;
  logic flag_reg;
  logic below_event_reg;
  logic recover_event_reg;
  logic reset_req_reg;

  // ****************************************
  // Comparison result
  // ****************************************
  assign below_sel = core.source_select ? pin_below : supply_below;
  assign flag_next = core.detect_enable & below_sel;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= CTRL_RESET_BIT;
    end else if (clk_en) begin
      flag_reg <= flag_next;
    end
  end

  // ****************************************
  // Interrupt events on both edges of the flag
  // ****************************************
  // Disabling while below also gives a recovery event, as the flag drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      below_event_reg   <= 1'b0;
      recover_event_reg <= 1'b0;
    end else if (clk_en) begin
      below_event_reg   <= ~core.reset_or_irq_select & flag_next & ~flag_reg;
      recover_event_reg <= ~core.reset_or_irq_select & ~flag_next & flag_reg;
    end
  end

  // ****************************************
  // Reset request, level held while below
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_req_reg <= 1'b0;
    end else if (clk_en) begin
      reset_req_reg <= core.reset_or_irq_select & flag_next;
    end
  end

  assign core.below_threshold_flag = flag_reg;
  assign core.below_event          = below_event_reg;
  assign core.recover_event        = recover_event_reg;
  assign core.reset_req            = reset_req_reg;

endmodule

`default_nettype wire

// File: hdl/lvd_irq.sv
`default_nettype none

module lvd_irq
  import lvd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic [IRQ_W-1:0] event_in,
  input  wire logic             stat_wr,
  input  wire logic             mask_wr,
  input  wire logic [IRQ_W-1:0] wdata,
  output logic      [IRQ_W-1:0] status,
  output logic      [IRQ_W-1:0] mask,
  output logic                  irq
);

  logic [IRQ_W-1:0] status_next;

  // ****************************************
  // Sticky status, write one to clear
  // ****************************************
  // A new event wins over a clear in the same cycle
  assign status_next = (status & ~(stat_wr ? wdata : IRQ_RESET)) | event_in;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= IRQ_RESET;
    end else if (clk_en) begin
      status <= status_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask <= IRQ_RESET;
    end else if (clk_en && mask_wr) begin
      mask <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_next & (mask_wr ? wdata : mask));
    end
  end

endmodule

`default_nettype wire

// File: bench/lvd_cmp_model.sv
`default_nettype none
module lvd_cmp_model
  import lvd_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               comparator_enable,
  input  wire logic [LEVEL_W-1:0] threshold_level_select,
  input  wire logic [3:0]         supply_volt,
  input  wire logic               pin_low,
  output logic                    supply_below,
  output logic                    pin_below
);
  // *****
  // Comparator
  // *****
  // Stopped comparator gives garbage, so the block must mask it
  logic idle_pat = 1'b0;
  always @(posedge clk) begin
    idle_pat <= !idle_pat;
  end
  always_comb begin
    if (comparator_enable) begin
      supply_below = supply_volt < (4'hF - threshold_level_select);
      pin_below    = pin_low;
    end else begin
      supply_below = idle_pat;
      pin_below    = !idle_pat;
    end
  end
endmodule
`default_nettype wire

// File: bench/lvd_chk.sv
`default_nettype none
module lvd_chk
  import lvd_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               clk_en,
  input wire logic               hsel,
  input wire logic [ADDR_W-1:0]  haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic [31:0]        hrdata,
  input wire logic               hresp,
  input wire logic               supply_below,
  input wire logic               pin_below,
  input wire logic               comparator_enable,
  input wire logic               source_select,
  input wire logic [LEVEL_W-1:0] threshold_level_select,
  input wire logic               detector_reset_req,
  input wire logic               detector_reset_cause,
  input wire logic               irq
);
  // *****
  // Bus phase trackers
  // *****
  logic taken;
  logic sel_below;
  logic wr_q;
  logic rd_ctrl_q;
  assign taken = clk_en && hsel && hready && htrans == HTRANS_NONSEQ;
  assign sel_below = comparator_enable && (source_select ? pin_below : supply_below);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q      <= 1'b0;
      rd_ctrl_q <= 1'b0;
    end else begin
      wr_q      <= taken && hwrite;
      rd_ctrl_q <= taken && !hwrite && haddr == ADDR_W'(ADDR_CTRL);
    end
  end
  // *****
  // Properties
  // *****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_dphase;
    $past(wr_q);
  endsequence
  sequence s_ctrl_read;
    rd_ctrl_q;
  endsequence
  a_bus_always_okay: assert property ($past(rst_b) |-> hreadyout && hresp == HRESP_OKAY)
    else $error("bus slave not ready or not okay");
  a_irq_clear_write: assert property ($fell(irq) |-> s_wr_dphase)
    else $error("interrupt dropped without a write");
  a_level_hold: assert property (!$stable(threshold_level_select) |-> s_wr_dphase)
    else $error("level changed without a write");
  a_ctrl_hold: assert property (!$stable({comparator_enable, source_select}) |-> s_wr_dphase)
    else $error("control changed without a write");
  a_req_needs_low: assert property (detector_reset_req |-> $past(sel_below))
    else $error("reset request without low voltage");
  a_cause_follows_req: assert property ($past(detector_reset_req) |-> detector_reset_cause)
    else $error("cause flag missed a detector reset");
  a_cause_origin: assert property ($rose(detector_reset_cause) |-> $past(detector_reset_req))
    else $error("cause flag set without a request");
  a_ctrl_read_fields: assert property (s_ctrl_read |-> hrdata[6:3] == 4'h0 && hrdata[0] == $past(sel_below, 2)
    && hrdata[7] == $past(comparator_enable))
    else $error("control read returned wrong fields");
endmodule
bind lvd_top lvd_chk #(.ADDR_W(ADDR_W)) u_lvd_chk (
  .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .supply_below(supply_below), .pin_below(pin_below), .comparator_enable(comparator_enable),
  .source_select(source_select), .threshold_level_select(threshold_level_select),
  .detector_reset_req(detector_reset_req), .detector_reset_cause(detector_reset_cause), .irq(irq)
);
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench
  import lvd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic        supply_below, pin_below, comparator_enable, source_select, irq;
  logic        detector_reset_req, detector_reset_cause, pin_low, src, p;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, r;
  logic [3:0]  level_out, supply_volt, lvl, v;
  logic [7:0]  map [6] = '{ADDR_CTRL, ADDR_LEVEL, ADDR_CAUSE, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h1C};
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 50907;
  assign hready = hreadyout;
  lvd_top #(.ADDR_W(8)) dut (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .supply_below(supply_below), .pin_below(pin_below),
    .comparator_enable(comparator_enable), .source_select(source_select),
    .threshold_level_select(level_out), .detector_reset_req(detector_reset_req),
    .detector_reset_cause(detector_reset_cause), .irq(irq)
  );
  lvd_cmp_model u_cmp (
    .clk(clk), .comparator_enable(comparator_enable), .threshold_level_select(level_out),
    .supply_volt(supply_volt), .pin_low(pin_low), .supply_below(supply_below), .pin_below(pin_below)
  );
  // *****
  // Helpers
  // *****
  function automatic logic [31:0] ctrl_exp(logic en, logic s, logic m, logic [3:0] vv, logic [3:0] l, logic pp);
    logic b;
    b = en && (s ? pp : (vv < 4'hF - l));
    return {24'h0, en, 4'h0, s, m, b};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    ahb(a, 1'b1, wd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      print_verdict();
    end
  end
  // *****
  // Main sequence
  // *****
  initial begin
    {rst_b, hwrite, pin_low} = 3'h0;
    {clk_en, hsel} = 2'h3;
    {haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    supply_volt = 4'hF;
    idle(8);
    rst_b <= 1'b1;
    idle(1);
    for (int i = 0; i < 6; i++) rdchk(map[i], 32'h0);
    wr(ADDR_CTRL, 32'hFF);
    rdchk(ADDR_CTRL, 32'h86);
    wr(ADDR_CTRL_CLR, 32'h84);
    rdchk(ADDR_CTRL, 32'h02);
    wr(ADDR_CTRL_SET, 32'h80);
    rdchk(ADDR_CTRL, 32'h82);
    $display("test fields done");
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      lvl = (i < 2) ? 4'h0 : r[3:0];
      v = (i < 2) ? 4'hE + 4'(i) : r[7:4];
      src = (i < 2) ? 1'b0 : r[8];
      p = r[9];
      supply_volt <= v;
      pin_low <= p;
      wr(ADDR_LEVEL, {28'h0, lvl});
      wr(ADDR_CTRL, {24'h0, 1'b1, 4'h0, src, 2'h0});
      idle(2);
      rdchk(ADDR_CTRL, ctrl_exp(1'b1, src, 1'b0, v, lvl, p));
      check(level_out, lvl);
      check({comparator_enable, source_select}, {1'b1, src});
      wr(ADDR_CTRL, {24'h0, 5'h0, src, 2'h0});
      idle(2);
      rdchk(ADDR_CTRL, ctrl_exp(1'b0, src, 1'b0, v, lvl, p));
      check(irq, 1'b0);
    end
    $display("test random compare done");
    supply_volt <= 4'hF;
    wr(ADDR_LEVEL, 32'h0);
    wr(ADDR_CTRL, 32'h80);
    idle(3);
    wr(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_MASK, 32'h3);
    check(irq, 1'b0);
    clk_en <= 1'b0;
    supply_volt <= 4'h0;
    idle(5);
    check(irq, 1'b0);
    clk_en <= 1'b1;
    idle(5);
    check(irq, 1'b1);
    rdchk(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    idle(1);
    check(irq, 1'b0);
    supply_volt <= 4'hF;
    idle(5);
    rdchk(ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h2);
    supply_volt <= 4'h0;
    idle(5);
    wr(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    idle(5);
    rdchk(ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_CAUSE, 32'h1);
    rdchk(ADDR_CAUSE, 32'h0);
    $display("test interrupt done");
    wr(ADDR_CTRL, 32'h82);
    idle(3);
    check(detector_reset_req, 1'b1);
    check(detector_reset_cause, 1'b1);
    rdchk(ADDR_CAUSE, 32'h1);
    rdchk(ADDR_IRQ_STAT, 32'h0);
    supply_volt <= 4'hF;
    idle(3);
    check(detector_reset_req, 1'b0);
    rdchk(ADDR_CTRL, 32'h82);
    wr(ADDR_CAUSE, 32'h1);
    rdchk(ADDR_CAUSE, 32'h0);
    wr(ADDR_CTRL, 32'h86);
    pin_low <= 1'b1;
    idle(3);
    check(detector_reset_req, 1'b1);
    pin_low <= 1'b0;
    wr(ADDR_LEVEL, 32'h5);
    $display("test reset mode done");
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    idle(1);
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_LEVEL, 32'h0);
    rdchk(ADDR_CAUSE, 32'h0);
    rdchk(ADDR_IRQ_MASK, 32'h0);
    $display("test external reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
